// ===== rtl/timer_channel.sv
// Purpose: One 16-bit timer channel: waveform lines, value registers, status.
// Assumes: All inputs synchronous to MCLK; EXT_EVENT and CAPTURE_x are pulses.
// Notes: Registers sit on an Avalon-MM slave with a fixed one-cycle wait.
//
// How it works
// [R1] Compare C match in waveform mode drives line A per its action field.
// [R2] External event drives line A per its own action field.
// [R3] Software trigger drives line A per its own action field.
// [R4] Compare B match drives line B per its action field.
// [R5] Compare C match drives line B per its own action field.
// [R6] External event drives line B per its own action field.
// [R7] Software trigger drives line B per its own action field.
// [R8] Count register reads the live counter in the low half, ignores writes.
// [R9] Value A reads live, is loaded by capture, writable only in waveform mode.
// [R10] Value B reads live, is loaded by capture, writable only in waveform mode.
// [R11] Value C reads live and is writable in both modes.
// [R12] Overflow flag sets on counter wrap and clears on status read.
// [R13] Overrun flag sets when A or B reloads before being read, capture only.
// [R14] Match A flag records compare A events, waveform only.
// [R15] Match B flag records compare B events, waveform only.
// [R16] Match C flag records compare C events in either mode.
// [R17] Load A flag records captures into A, capture mode only.
// [R18] Load B flag records captures into B, capture mode only.
// [R19] External trigger flag records external events in either mode.
// [R20] Clock-on bit shows the counter clock enable state live.
// [R21] Line level bits show pin level in capture, driven level in waveform.
// [R22] Mode bit selects capture at 0 and waveform at 1.
// [R23] An event in the cycle of its status read stays set afterwards.
`timescale 1ns/10ps
`default_nettype none
module timer_channel #(
  parameter int unsigned TICK_DIV = timer_channel_pkg::TICK_DIV_DEF
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic EXT_EVENT,
  input wire logic CAPTURE_A,
  input wire logic CAPTURE_B,
  input wire logic LINE_A_PIN_I,
  output logic LINE_A_PIN_O,
  output logic LINE_A_PIN_OE_N,
  input wire logic LINE_B_PIN_I,
  output logic LINE_B_PIN_O,
  output logic LINE_B_PIN_OE_N
);

  // ==========================================================
  // Action helper

  function automatic logic apply_act(input logic lvl, input logic [1:0] act);
    logic res;
    res = lvl;
    unique case (timer_channel_pkg::action_t'(act))
      timer_channel_pkg::ACT_NONE: res = lvl;
      timer_channel_pkg::ACT_SET: res = 1'b1;
      timer_channel_pkg::ACT_CLEAR: res = 1'b0;
      timer_channel_pkg::ACT_TOGGLE: res = ~lvl;
    endcase
    return res;
  endfunction

  // ==========================================================
  // State

  timer_channel_pkg::bus_state_t state_ff;
  timer_channel_pkg::bus_state_t nxt_state;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [16:0] mode_ff;
  logic [16:0] nxt_mode;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] val_a_ff;
  logic [15:0] nxt_val_a;
  logic [15:0] val_b_ff;
  logic [15:0] nxt_val_b;
  logic [15:0] val_c_ff;
  logic [15:0] nxt_val_c;
  logic clk_on_ff;
  logic nxt_clk_on;
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic a_unread_ff;
  logic b_unread_ff;
  logic line_a_ff;
  logic line_b_ff;
  logic oe_n_ff;
  logic [timer_channel_pkg::DIV_W-1:0] div_ff;
  logic [timer_channel_pkg::DIV_W-1:0] nxt_div;

  // ==========================================================
  // Bus decode

  wire [3:0] word = AVS_ADDRESS[5:2];
  wire bus_req = AVS_READ | AVS_WRITE;
  wire acc_done = (state_ff == timer_channel_pkg::BUS_ACK);
  wire wr_done = acc_done & AVS_WRITE;
  wire rd_done = acc_done & AVS_READ;
  wire sel_mode = (word == timer_channel_pkg::IDX_MODE);
  wire sel_cmd = (word == timer_channel_pkg::IDX_CMD);
  wire sel_count = (word == timer_channel_pkg::IDX_COUNT);
  wire sel_val_a = (word == timer_channel_pkg::IDX_VAL_A);
  wire sel_val_b = (word == timer_channel_pkg::IDX_VAL_B);
  wire sel_val_c = (word == timer_channel_pkg::IDX_VAL_C);
  wire sel_sr = (word == timer_channel_pkg::IDX_SR);
  wire [31:0] be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                         {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  wire [31:0] wd = AVS_WRITEDATA & be_mask;
  wire [31:0] keep = ~be_mask;

  // Selects capture at 0 and waveform at 1. [R22]
  wire wave = mode_ff[timer_channel_pkg::MODE_WAVE];

  // ==========================================================
  // Events

  wire tick = clk_on_ff & (div_ff == '0);
  wire ovf_ev = tick & (cnt_ff == timer_channel_pkg::CNT_MAX);
  wire ma_ev = wave & tick & (cnt_ff == val_a_ff);
  wire mb_ev = wave & tick & (cnt_ff == val_b_ff);
  wire mc_ev = tick & (cnt_ff == val_c_ff);
  wire cmd_wr = wr_done & sel_cmd & AVS_BYTEENABLE[0];
  wire sw_ev = cmd_wr & AVS_WRITEDATA[timer_channel_pkg::CMD_SW_TRIG];
  wire clk_en = cmd_wr & AVS_WRITEDATA[timer_channel_pkg::CMD_CLK_EN];
  wire clk_dis = cmd_wr & AVS_WRITEDATA[timer_channel_pkg::CMD_CLK_DIS];
  wire ext_ev = EXT_EVENT;
  wire cap_a = ~wave & CAPTURE_A;
  wire cap_b = ~wave & CAPTURE_B;
  wire rd_val_a = rd_done & sel_val_a;
  wire rd_val_b = rd_done & sel_val_b;
  wire lovr_ev = (cap_a & a_unread_ff) | (cap_b & b_unread_ff);

  // ==========================================================
  // Line actions

  wire [1:0] f_a_on_a = mode_ff[timer_channel_pkg::MODE_A_ON_A +: 2];
  wire [1:0] f_a_on_c = mode_ff[timer_channel_pkg::MODE_A_ON_C +: 2];
  wire [1:0] f_a_on_ext = mode_ff[timer_channel_pkg::MODE_A_ON_EXT +: 2];
  wire [1:0] f_a_on_sw = mode_ff[timer_channel_pkg::MODE_A_ON_SW +: 2];
  wire [1:0] f_b_on_b = mode_ff[timer_channel_pkg::MODE_B_ON_B +: 2];
  wire [1:0] f_b_on_c = mode_ff[timer_channel_pkg::MODE_B_ON_C +: 2];
  wire [1:0] f_b_on_ext = mode_ff[timer_channel_pkg::MODE_B_ON_EXT +: 2];
  wire [1:0] f_b_on_sw = mode_ff[timer_channel_pkg::MODE_B_ON_SW +: 2];

  // Coincident events never stack: the highest one with a non-zero field wins,
  // software trigger first, then external event, then compare C, then A or B.
  wire [1:0] act_a = (sw_ev && f_a_on_sw != 2'h0) ? f_a_on_sw :   // [R3]
                     (ext_ev && f_a_on_ext != 2'h0) ? f_a_on_ext : // [R2]
                     (mc_ev && f_a_on_c != 2'h0) ? f_a_on_c :     // [R1]
                     ma_ev ? f_a_on_a : 2'h0;
  wire [1:0] act_b = (sw_ev && f_b_on_sw != 2'h0) ? f_b_on_sw :   // [R7]
                     (ext_ev && f_b_on_ext != 2'h0) ? f_b_on_ext : // [R6]
                     (mc_ev && f_b_on_c != 2'h0) ? f_b_on_c :     // [R5]
                     mb_ev ? f_b_on_b : 2'h0;                     // [R4]
  wire nxt_line_a = wave ? apply_act(line_a_ff, act_a) : line_a_ff;
  wire nxt_line_b = wave ? apply_act(line_b_ff, act_b) : line_b_ff;

  // ==========================================================
  // Status view

  // Pin level in capture, driven level in waveform. [R21]
  wire lvl_a = wave ? line_a_ff : LINE_A_PIN_I;
  wire lvl_b = wave ? line_b_ff : LINE_B_PIN_I;
  wire [7:0] flag_view = flags_ff & {1'b1, ~wave, ~wave, 1'b1, wave, wave, ~wave, 1'b1};
  wire [31:0] sr_view = {13'h0000, lvl_b, lvl_a, clk_on_ff, 8'h00, flag_view}; // [R20]
  wire [7:0] ev = {ext_ev,                     // [R19]
                   cap_b,                      // [R18]
                   cap_a,                      // [R17]
                   mc_ev,                      // [R16]
                   mb_ev,                      // [R15]
                   ma_ev,                      // [R14]
                   lovr_ev,                    // [R13]
                   ovf_ev};                    // [R12]
  // Only bits that were in the returned word are cleared, so an event that
  // lands between sampling and completion survives; set also beats clear.
  wire [7:0] clr_mask = (rd_done & sel_sr) ? rdata_ff[7:0] : 8'h00;

  wire [31:0] rd_mux = sel_mode ? {15'h0000, mode_ff} :
                       sel_count ? {16'h0000, cnt_ff} :  // [R8]
                       sel_val_a ? {16'h0000, val_a_ff} : // [R9]
                       sel_val_b ? {16'h0000, val_b_ff} : // [R10]
                       sel_val_c ? {16'h0000, val_c_ff} : // [R11]
                       sel_sr ? sr_view : 32'h00000000;

  // ==========================================================
  // Next-state logic

  always_comb begin
    nxt_state = state_ff;
    if (state_ff == timer_channel_pkg::BUS_IDLE && bus_req) begin
      nxt_state = timer_channel_pkg::BUS_ACK;
    end else if (acc_done) begin
      nxt_state = timer_channel_pkg::BUS_IDLE;
    end
  end

  always_comb begin
    nxt_mode = mode_ff;
    if (wr_done && sel_mode) begin
      nxt_mode = (mode_ff & keep[16:0]) | (wd[16:0] & timer_channel_pkg::MODE_USED);
    end
  end

  always_comb begin
    nxt_cnt = cnt_ff;
    if (sw_ev) begin
      nxt_cnt = timer_channel_pkg::VALUE_RESET;
    end else if (tick) begin
      nxt_cnt = 16'(cnt_ff + 16'h0001);
    end
  end

  // Capture has priority; software writes to A and B apply only in waveform mode, writes to C in both.
  always_comb begin
    nxt_val_a = val_a_ff;
    nxt_val_b = val_b_ff;
    nxt_val_c = val_c_ff;
    if (cap_a) begin
      nxt_val_a = cnt_ff;
    end else if (wave && wr_done && sel_val_a) begin
      nxt_val_a = (val_a_ff & keep[15:0]) | wd[15:0]; // [R9]
    end
    if (cap_b) begin
      nxt_val_b = cnt_ff;
    end else if (wave && wr_done && sel_val_b) begin
      nxt_val_b = (val_b_ff & keep[15:0]) | wd[15:0]; // [R10]
    end
    if (wr_done && sel_val_c) begin
      nxt_val_c = (val_c_ff & keep[15:0]) | wd[15:0]; // [R11]
    end
  end

  // Disable beats enable and software trigger when written together.
  always_comb begin
    nxt_clk_on = clk_on_ff;
    if (clk_dis) begin
      nxt_clk_on = 1'b0;
    end else if (clk_en || sw_ev) begin
      nxt_clk_on = 1'b1;
    end
  end

  always_comb begin
    nxt_div = div_ff;
    if (sw_ev || !clk_on_ff || div_ff == '0) begin
      nxt_div = timer_channel_pkg::DIV_W'(TICK_DIV - 1);
    end else begin
      nxt_div = timer_channel_pkg::DIV_W'(div_ff - 1'b1);
    end
  end

  assign nxt_flags = (flags_ff & ~clr_mask) | ev; // [R23]

  // ==========================================================
  // Registers

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_ff <= timer_channel_pkg::BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      wait_ff <= (nxt_state != timer_channel_pkg::BUS_ACK);
      if (state_ff == timer_channel_pkg::BUS_IDLE && AVS_READ) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      mode_ff <= timer_channel_pkg::MODE_RESET;
      cnt_ff <= timer_channel_pkg::VALUE_RESET;
      val_a_ff <= timer_channel_pkg::VALUE_RESET;
      val_b_ff <= timer_channel_pkg::VALUE_RESET;
      val_c_ff <= timer_channel_pkg::VALUE_RESET;
      clk_on_ff <= 1'b0;
      div_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
      cnt_ff <= nxt_cnt;
      val_a_ff <= nxt_val_a;
      val_b_ff <= nxt_val_b;
      val_c_ff <= nxt_val_c;
      clk_on_ff <= nxt_clk_on;
      div_ff <= nxt_div;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      flags_ff <= 8'h00;
      a_unread_ff <= 1'b0;
      b_unread_ff <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      a_unread_ff <= cap_a | (a_unread_ff & ~rd_val_a); // [R13]
      b_unread_ff <= cap_b | (b_unread_ff & ~rd_val_b); // [R13]
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      line_a_ff <= 1'b0;
      line_b_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      line_a_ff <= nxt_line_a;
      line_b_ff <= nxt_line_b;
      oe_n_ff <= ~nxt_mode[timer_channel_pkg::MODE_WAVE];
    end
  end

  assign AVS_READDATA = rdata_ff;
  assign AVS_WAITREQUEST = wait_ff;
  assign LINE_A_PIN_O = line_a_ff;
  assign LINE_B_PIN_O = line_b_ff;
  assign LINE_A_PIN_OE_N = oe_n_ff;
  assign LINE_B_PIN_OE_N = oe_n_ff;

  // ==========================================================
  // Assertions

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  match_c_a_a: assert property (wave && mc_ev && !sw_ev && !ext_ev && // [R1]
      f_a_on_c == 2'h1 |=> line_a_ff)
    else $error("line A not set on compare C");
  ext_a_a: assert property (wave && ext_ev && !sw_ev && // [R2]
      f_a_on_ext == 2'h3 |=> line_a_ff != $past(line_a_ff))
    else $error("line A not toggled on external event");
  sw_line_a_a: assert property (wave && sw_ev && f_a_on_sw == 2'h2 // [R3]
      |=> !line_a_ff)
    else $error("line A not cleared on software trigger");
  match_b_b_a: assert property (wave && mb_ev && !mc_ev && !sw_ev && // [R4]
      !ext_ev && f_b_on_b == 2'h3 |=> line_b_ff != $past(line_b_ff))
    else $error("line B not toggled on compare B");
  sw_line_b_a: assert property (wave && sw_ev && f_b_on_sw == 2'h1 // [R7]
      |=> line_b_ff)
    else $error("line B not set on software trigger");
  count_live_a: assert property (state_ff == timer_channel_pkg::BUS_IDLE && // [R8]
      AVS_READ && sel_count ##1 rd_done |-> AVS_READDATA == {16'h0000, $past(cnt_ff)})
    else $error("count read does not return counter");
  val_a_lock_a: assert property (!wave && !CAPTURE_A ##1 !wave && !CAPTURE_A // [R9]
      |-> $stable(val_a_ff))
    else $error("value A changed in capture mode without capture");
  ovf_sticky_a: assert property ((ovf_ev || (flags_ff[timer_channel_pkg::SR_OVF] && // [R12]
      !(rd_done && sel_sr))) |=> flags_ff[timer_channel_pkg::SR_OVF])
    else $error("overflow flag not held");
  overrun_a: assert property (cap_b && b_unread_ff && !rd_val_b // [R13]
      |=> flags_ff[timer_channel_pkg::SR_LOVR])
    else $error("load overrun not flagged");
  match_mode_a: assert property (rd_done && sel_sr && !$past(wave) // [R14]
      |-> AVS_READDATA[timer_channel_pkg::SR_MATCH_B:timer_channel_pkg::SR_MATCH_A] == 2'b00)
    else $error("match flags visible in capture mode");
  set_wins_a: assert property (mc_ev && rd_done && sel_sr // [R23]
      |=> flags_ff[timer_channel_pkg::SR_MATCH_C])
    else $error("event lost on status read");
  sw_start_a: assert property (sw_ev && !clk_dis // [R20]
      |=> clk_on_ff && cnt_ff == 16'h0000 && sr_view[timer_channel_pkg::SR_CLK_ON])
    else $error("software trigger did not restart counter");

endmodule
`default_nettype wire

// ===== rtl/timer_channel_pkg.sv
// Purpose: Shared constants for the timer channel block.
// Assumes: Word-aligned 32-bit registers on an Avalon-MM slave port.
// Notes: Field positions and offsets are used by both design and bench.
`default_nettype none
package timer_channel_pkg;
  // ==========================================================
  // Register word indexes (byte address = index * 4)
  localparam logic [3:0] IDX_MODE = 4'h0;
  localparam logic [3:0] IDX_CMD = 4'h1;
  localparam logic [3:0] IDX_COUNT = 4'h4;
  localparam logic [3:0] IDX_VAL_A = 4'h5;
  localparam logic [3:0] IDX_VAL_B = 4'h6;
  localparam logic [3:0] IDX_VAL_C = 4'h7;
  localparam logic [3:0] IDX_SR = 4'h8;
  // ==========================================================
  // Mode register fields (each action field is two bits wide)
  localparam int MODE_WAVE = 0;
  localparam int MODE_A_ON_A = 1;
  localparam int MODE_A_ON_C = 3;
  localparam int MODE_A_ON_EXT = 5;
  localparam int MODE_A_ON_SW = 7;
  localparam int MODE_B_ON_B = 9;
  localparam int MODE_B_ON_C = 11;
  localparam int MODE_B_ON_EXT = 13;
  localparam int MODE_B_ON_SW = 15;
  localparam logic [16:0] MODE_USED = 17'h1FFFF;
  // ==========================================================
  // Command register bits
  localparam int CMD_CLK_EN = 0;
  localparam int CMD_CLK_DIS = 1;
  localparam int CMD_SW_TRIG = 2;
  // ==========================================================
  // Status register bits
  localparam int SR_OVF = 0;
  localparam int SR_LOVR = 1;
  localparam int SR_MATCH_A = 2;
  localparam int SR_MATCH_B = 3;
  localparam int SR_MATCH_C = 4;
  localparam int SR_LOAD_A = 5;
  localparam int SR_LOAD_B = 6;
  localparam int SR_EXT = 7;
  localparam int SR_CLK_ON = 16;
  localparam int SR_LVL_A = 17;
  localparam int SR_LVL_B = 18;
  // ==========================================================
  // Reset values and counts
  localparam logic [16:0] MODE_RESET = 17'h00000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam int unsigned TICK_DIV_DEF = 1;
  localparam int DIV_W = 8;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_SET = 2'h1,
    ACT_CLEAR = 2'h2,
    ACT_TOGGLE = 2'h3
  } action_t;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;
endpackage
`default_nettype wire

// ===== bench/line_partner.sv
// Purpose: External circuitry on the two timer lines.
// Assumes: The circuitry drives its own level whenever the channel releases a line.
// Notes: A line the channel drives reads back as the driven level.
`timescale 1ns/10ps
`default_nettype none
module line_partner (
  input wire logic ext_a,
  input wire logic ext_b,
  input wire logic out_a,
  input wire logic oe_n_a,
  input wire logic out_b,
  input wire logic oe_n_b,
  output logic pin_a,
  output logic pin_b
);
  // ==========================================================
  // Wire resolution
  // The far side is a strong driver, so a released line never shows a stale level.
  assign pin_a = oe_n_a ? ext_a : out_a;
  assign pin_b = oe_n_b ? ext_b : out_b;
endmodule
`default_nettype wire

// ===== bench/timer_channel_test.sv
// Purpose: Register-level tests of the timer channel.
// Assumes: TICK_DIV of 1, so the counter steps every clock while on.
// Notes: Compare events are made by a software trigger and a bounded run.
`timescale 1ns/10ps
`default_nettype none
module timer_channel_test;
  logic MCLK, SRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic EXT_EVENT, CAPTURE_A, CAPTURE_B;
  logic [5:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic LINE_A_PIN_I, LINE_A_PIN_O, LINE_A_PIN_OE_N;
  logic LINE_B_PIN_I, LINE_B_PIN_O, LINE_B_PIN_OE_N;
  logic ext_a, ext_b, la, lb;
  logic [31:0] rd, cnt_held;
  int errors, num_checks;
  int apos[4] = '{timer_channel_pkg::MODE_A_ON_SW, timer_channel_pkg::MODE_A_ON_EXT,
    timer_channel_pkg::MODE_A_ON_C, timer_channel_pkg::MODE_A_ON_A};
  int bpos[4] = '{timer_channel_pkg::MODE_B_ON_SW, timer_channel_pkg::MODE_B_ON_EXT,
    timer_channel_pkg::MODE_B_ON_C, timer_channel_pkg::MODE_B_ON_B};

  timer_channel #(.TICK_DIV(1)) timer_channel_i (
    .MCLK(MCLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .EXT_EVENT(EXT_EVENT), .CAPTURE_A(CAPTURE_A), .CAPTURE_B(CAPTURE_B),
    .LINE_A_PIN_I(LINE_A_PIN_I), .LINE_A_PIN_O(LINE_A_PIN_O),
    .LINE_A_PIN_OE_N(LINE_A_PIN_OE_N), .LINE_B_PIN_I(LINE_B_PIN_I),
    .LINE_B_PIN_O(LINE_B_PIN_O), .LINE_B_PIN_OE_N(LINE_B_PIN_OE_N));

  line_partner line_partner_i (
    .ext_a(ext_a), .ext_b(ext_b), .out_a(LINE_A_PIN_O), .oe_n_a(LINE_A_PIN_OE_N),
    .out_b(LINE_B_PIN_O), .oe_n_b(LINE_B_PIN_OE_N), .pin_a(LINE_A_PIN_I),
    .pin_b(LINE_B_PIN_I));

  always #5 MCLK = ~MCLK;

  // ==========================================================
  // Helpers
  task automatic close_out();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The request is held until waitrequest is sampled low; data is taken at that edge.
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                     output logic [31:0] rdat);
    int n;
    @(posedge MCLK);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    rdat = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (n >= 20) begin
      errors++;
      close_out();
    end
  endtask

  task automatic wr_reg(input logic [3:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, idx, wd, dummy);
  endtask

  task automatic rd_reg(input logic [3:0] idx, output logic [31:0] rdat);
    bus(1'b0, idx, 32'h0, rdat);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  function automatic logic act(input logic cur, input logic [1:0] code);
    case (code)
      2'h1: return 1'b1;
      2'h2: return 1'b0;
      2'h3: return ~cur;
      default: return cur;
    endcase
  endfunction

  function automatic logic [31:0] lvl(input logic a, input logic b);
    return {13'h0, b, a, 17'h0};
  endfunction

  // ==========================================================
  // One event source with one action code on line A and its inverse code on line B
  task automatic run_case(input int src, input logic [1:0] code);
    logic [31:0] d;
    logic [31:0] m;
    m = 32'h1 | (32'(code) << apos[src]) | (32'(2'h3 - code) << bpos[src]);
    wr_reg(timer_channel_pkg::IDX_MODE, m);
    rd_reg(timer_channel_pkg::IDX_SR, d);
    if (src == 1) begin
      @(posedge MCLK);
      EXT_EVENT <= 1'b1;
      @(posedge MCLK);
      EXT_EVENT <= 1'b0;
    end else begin
      wr_reg(timer_channel_pkg::IDX_CMD, 32'h4);
    end
    if (src >= 2) begin
      ticks(64);
    end
    wr_reg(timer_channel_pkg::IDX_CMD, 32'h2);
    la = act(la, code);
    lb = act(lb, 2'h3 - code);
    check({30'h0, LINE_B_PIN_O, LINE_A_PIN_O}, {30'h0, lb, la});
    check({30'h0, LINE_B_PIN_OE_N, LINE_A_PIN_OE_N}, 32'h0);
    if (src != 0) begin
      rd_reg(timer_channel_pkg::IDX_SR, d);
      check(d, ((src == 1) ? 32'h80 : 32'h1C) | lvl(la, lb));
      rd_reg(timer_channel_pkg::IDX_SR, d);
      check(d, lvl(la, lb));
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    MCLK = 1'b0;
    SRST = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 6'h00;
    AVS_WRITEDATA = 32'h0;
    EXT_EVENT = 1'b0;
    CAPTURE_A = 1'b0;
    CAPTURE_B = 1'b0;
    ext_a = 1'b1;
    ext_b = 1'b0;
    la = 1'b0;
    lb = 1'b0;
    errors = 0;
    num_checks = 0;
    repeat (16) @(posedge MCLK);
    SRST <= 1'b0;
    @(posedge MCLK);
    check({29'h0, AVS_WAITREQUEST, LINE_B_PIN_OE_N, LINE_A_PIN_OE_N}, 32'h7);
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    check(rd, lvl(1'b1, 1'b0));
    rd_reg(timer_channel_pkg::IDX_COUNT, rd);
    check(rd, 32'h0);
    wr_reg(4'h2, 32'hFFFF);
    rd_reg(4'h2, rd);
    check(rd, 32'h0);
    wr_reg(timer_channel_pkg::IDX_VAL_A, 32'h1234);
    rd_reg(timer_channel_pkg::IDX_VAL_A, rd);
    check(rd, 32'h0);
    wr_reg(timer_channel_pkg::IDX_VAL_B, 32'h5678);
    rd_reg(timer_channel_pkg::IDX_VAL_B, rd);
    check(rd, 32'h0);
    wr_reg(timer_channel_pkg::IDX_VAL_C, 32'h30);
    rd_reg(timer_channel_pkg::IDX_VAL_C, rd);
    check(rd, 32'h30);
    wr_reg(timer_channel_pkg::IDX_MODE, 32'h1);
    wr_reg(timer_channel_pkg::IDX_VAL_A, 32'h10);
    wr_reg(timer_channel_pkg::IDX_VAL_B, 32'h20);
    rd_reg(timer_channel_pkg::IDX_VAL_A, rd);
    check(rd, 32'h10);
    rd_reg(timer_channel_pkg::IDX_VAL_B, rd);
    check(rd, 32'h20);
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        run_case(s, 2'(c));
      end
    end
    // A full wrap of the counter takes 65536 ticks; the run stops well past value C.
    wr_reg(timer_channel_pkg::IDX_MODE, 32'h1);
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    wr_reg(timer_channel_pkg::IDX_CMD, 32'h4);
    ticks(65600);
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    check(rd, 32'h1001D | lvl(la, lb));
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    check(rd, 32'h10000 | lvl(la, lb));
    wr_reg(timer_channel_pkg::IDX_CMD, 32'h2);
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    check(rd, lvl(la, lb));
    wr_reg(timer_channel_pkg::IDX_CMD, 32'h1);
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    check(rd, 32'h10000 | lvl(la, lb));
    wr_reg(timer_channel_pkg::IDX_CMD, 32'h3);
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    check(rd, lvl(la, lb));
    rd_reg(timer_channel_pkg::IDX_COUNT, cnt_held);
    wr_reg(timer_channel_pkg::IDX_COUNT, 32'hFFFF);
    rd_reg(timer_channel_pkg::IDX_COUNT, rd);
    check(rd, cnt_held);
    wr_reg(timer_channel_pkg::IDX_MODE, 32'h0);
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    check(rd, lvl(1'b1, 1'b0));
    check({30'h0, LINE_B_PIN_OE_N, LINE_A_PIN_OE_N}, 32'h3);
    @(posedge MCLK);
    CAPTURE_A <= 1'b1;
    @(posedge MCLK);
    CAPTURE_A <= 1'b0;
    CAPTURE_B <= 1'b1;
    @(posedge MCLK);
    CAPTURE_B <= 1'b0;
    CAPTURE_A <= 1'b1;
    @(posedge MCLK);
    CAPTURE_A <= 1'b0;
    ticks(2);
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    check(rd, 32'h62 | lvl(1'b1, 1'b0));
    rd_reg(timer_channel_pkg::IDX_VAL_A, rd);
    check(rd, cnt_held);
    wr_reg(timer_channel_pkg::IDX_VAL_A, 32'hABCD);
    rd_reg(timer_channel_pkg::IDX_VAL_A, rd);
    check(rd, cnt_held);
    rd_reg(timer_channel_pkg::IDX_VAL_B, rd);
    check(rd, cnt_held);
    ext_a <= 1'b0;
    ext_b <= 1'b1;
    rd_reg(timer_channel_pkg::IDX_SR, rd);
    check(rd, lvl(1'b0, 1'b1));
    close_out();
  end

  // ==========================================================
  // Watchdog: the sequence needs about 70000 cycles.
  initial begin
    #(900000);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
